//--- hdl/pwr_mode_ctrl.sv
// Summary of operation
// [R01] writing idle bit enters idle
// [R02] select clear: disabled interrupt cannot wake
// [R03] select set: any flag wakes idle
// [R04] idle gates cpu clock, peripherals keep running
// [R05] idle: strobes high, ports keep data
// [R06] idle external memory: p2 address, p0 floats
// [R07] writing stop bit enters soft power down
// [R08] wake select governs stop exit too
// [R09] stop halts oscillator except timers 0,1
// [R10] low interrupt pin blocks stop entry
// [R11] full counter with high input blocks stop
// [R12] float select clear: ports keep driving
// [R13] software sets float select before stop
// [R14] floating ports disable all drivers
// [R15] float stop: p3.2-5 inputs, strobes low
// [R16] float select at io control bit 0
// [R17] reset releases either mode
// [R18] release clears the mode request bit
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "pwr_mode_defines.svh"
module pwr_mode_ctrl
    import pwr_mode_pkg::*;
#(
    parameter int N_IRQ = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [N_IRQ-1:0] irq_flag,
    input wire logic [N_IRQ-1:0] irq_enable,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic count_input0,
    input wire logic count_input1,
    input wire logic [1:0] count_ext_mode,
    input wire logic [7:0] count_value0,
    input wire logic [7:0] count_value1,
    input wire logic ext_program_mode,
    input wire logic [7:0] addr_high,
    input wire logic [31:0] port_latch,
    input wire logic run_fetch_strobe,
    input wire logic run_ale,
    output logic cpu_clk_en,
    output logic osc_en,
    output logic periph_clk_en,
    output logic count01_clk_en,
    output logic resume_next,
    output logic [31:0] port_out,
    output logic [31:0] port_oe,
    output logic program_fetch_strobe,
    output logic ale_out,
    output logic [1:0] mode_state
);
    // =====================================
    // registers
    logic [7:0] power_control_reg;
    logic [7:0] io_control_reg;
    pwr_mode_t mode;
    logic float_latched;
    logic wake;
    logic stop_blocked;
    logic wr_power_control;
    logic wr_io_control_reg;
    logic idle_req;
    logic stop_req;
    logic wake_sel;

    assign wr_power_control = reg_wr && (reg_addr == `POWER_CONTROL_ADDR);
    assign wr_io_control_reg = reg_wr && (reg_addr == `IO_CONTROL_ADDR);
    assign idle_req = wr_power_control && reg_wdata[`IDLE_REQ_POS] && (mode == MODE_RUN);
    assign stop_req = wr_power_control && reg_wdata[`STOP_REQ_POS] && (mode == MODE_RUN);
    // stop entry is judged with the select being written alongside
    assign wake_sel = (wr_power_control && mode == MODE_RUN) ? reg_wdata[`WAKE_SEL_POS]
        : power_control_reg[`WAKE_SEL_POS];

    wake_source #(
        .N(N_IRQ)
    ) u_wake (
        .irq_flag(irq_flag),
        .irq_enable(irq_enable),
        .wake_on_flag_select(wake_sel),
        .ext_irq0_pin(ext_irq0_pin),
        .ext_irq1_pin(ext_irq1_pin),
        .count_input0(count_input0),
        .count_input1(count_input1),
        .count_ext_mode(count_ext_mode),
        .count_value0(count_value0),
        .count_value1(count_value1),
        .wake(wake),
        .stop_blocked(stop_blocked)
    );

    // =====================================
    // power control register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            power_control_reg <= `POWER_CONTROL_RESET; // R17
        end else if (mode != MODE_RUN && wake) begin
            power_control_reg[`IDLE_REQ_POS] <= 1'b0; // R18
            power_control_reg[`STOP_REQ_POS] <= 1'b0; // R18
        end else if (wr_power_control) begin
            power_control_reg <= reg_wdata;
            // refused stop entry leaves request clear
            if (reg_wdata[`STOP_REQ_POS] && !reg_wdata[`IDLE_REQ_POS] && stop_blocked) begin
                power_control_reg[`STOP_REQ_POS] <= 1'b0; // R10 R11
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_control_reg <= `IO_CONTROL_RESET;
        end else if (wr_io_control_reg) begin
            io_control_reg <= reg_wdata; // R16
        end
    end

    // =====================================
    // mode machine
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode <= MODE_RUN; // R17
        end else begin
            unique case (mode)
                MODE_RUN: begin
                    if (idle_req) begin
                        mode <= MODE_IDLE; // R01
                    end else if (stop_req && !stop_blocked) begin
                        mode <= MODE_STOP; // R07
                    end
                end
                MODE_IDLE: begin
                    if (wake) begin
                        mode <= MODE_RUN; // R02 R03
                    end
                end
                MODE_STOP: begin
                    if (wake) begin
                        mode <= MODE_RUN; // R08
                    end
                end
                default: begin
                    mode <= MODE_RUN;
                end
            endcase
        end
    end

    // float choice captured on stop entry
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            float_latched <= 1'b0;
        end else if (mode == MODE_RUN && stop_req && !idle_req && !stop_blocked) begin
            float_latched <= io_control_reg[`FLOAT_SEL_POS]; // R13
        end
    end

    // resume after entering instruction when woken by flag only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resume_next <= 1'b0;
        end else begin
            resume_next <= (mode != MODE_RUN) && wake && !(|(irq_flag & irq_enable)); // R03 R08
        end
    end

    // =====================================
    // read port
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `POWER_CONTROL_ADDR: reg_rdata <= power_control_reg;
                `IO_CONTROL_ADDR: reg_rdata <= io_control_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // =====================================
    // clock gating
    assign cpu_clk_en = (mode == MODE_RUN); // R04 R09
    assign osc_en = (mode != MODE_STOP); // R09
    assign periph_clk_en = (mode != MODE_STOP); // R04
    assign count01_clk_en = 1'b1; // R09
    assign mode_state = mode;

    // =====================================
    // pins
    logic floating;
    logic [31:0] float_mask;
    assign floating = (mode == MODE_STOP) && float_latched;
    // p3.2 to p3.5 stay inputs (port 3 is bits 31:24)
    assign float_mask = 32'h3c00_0000;

    always_comb begin
        port_out = port_latch;
        port_oe = 32'hffff_ffff;
        program_fetch_strobe = run_fetch_strobe;
        ale_out = run_ale;
        unique case (mode)
            MODE_IDLE: begin
                program_fetch_strobe = 1'b1; // R05
                ale_out = 1'b1; // R05
                if (ext_program_mode) begin
                    port_out[23:16] = addr_high; // R06
                    port_oe[7:0] = 8'h00; // R06
                end
            end
            MODE_STOP: begin
                program_fetch_strobe = 1'b0; // R15
                ale_out = 1'b0; // R15
                if (floating) begin
                    port_oe = 32'h0000_0000; // R14
                end else begin
                    port_oe = 32'hffff_ffff; // R12
                end
                if (floating) begin
                    port_oe = port_oe & ~float_mask; // R15
                end
            end
            default: begin
                port_oe = 32'hffff_ffff;
            end
        endcase
    end
endmodule : pwr_mode_ctrl

//--- hdl/pwr_mode_defines.svh
`ifndef PWR_MODE_DEFINES_SVH
`define PWR_MODE_DEFINES_SVH
`define POWER_CONTROL_ADDR 8'h87
`define IO_CONTROL_ADDR 8'hf8
`define IDLE_REQ_POS 0
`define STOP_REQ_POS 1
`define WAKE_SEL_POS 5
`define FLOAT_SEL_POS 0
`define POWER_CONTROL_RESET 8'h00
`define IO_CONTROL_RESET 8'h00
`define COUNT_FULL 8'hff
`endif

//--- hdl/pwr_mode_pkg.sv
package pwr_mode_pkg;
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_STOP = 2'b10
    } pwr_mode_t;
endpackage : pwr_mode_pkg

//--- hdl/wake_source.sv
`timescale 1ns/100ps
`include "pwr_mode_defines.svh"
// per-source wake qualification and stop-entry blocking
module wake_source #(
    parameter int N = 6
) (
    input wire logic [N-1:0] irq_flag,
    input wire logic [N-1:0] irq_enable,
    input wire logic wake_on_flag_select,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic count_input0,
    input wire logic count_input1,
    input wire logic [1:0] count_ext_mode,
    input wire logic [7:0] count_value0,
    input wire logic [7:0] count_value1,
    output logic wake,
    output logic stop_blocked
);
    logic [N-1:0] can_wake;
    logic [3:0] pin_busy;
    logic [3:0] src_can;
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_src
            assign can_wake[i] = irq_enable[i] | wake_on_flag_select;
        end
    endgenerate
    // flag alone wakes only with select set
    assign wake = |(irq_flag & can_wake); // R02 R03 R08
    // sources: 0 ext0, 1 timer0, 2 ext1, 3 timer1
    assign src_can = {can_wake[3], can_wake[2], can_wake[1], can_wake[0]};
    assign pin_busy[0] = ~ext_irq0_pin; // R10
    assign pin_busy[2] = ~ext_irq1_pin; // R10
    assign pin_busy[1] = count_ext_mode[0] & (count_value0 == `COUNT_FULL) & count_input0; // R11
    assign pin_busy[3] = count_ext_mode[1] & (count_value1 == `COUNT_FULL) & count_input1; // R11
    assign stop_blocked = |(pin_busy & src_can);
endmodule : wake_source

//--- verif/pwr_mode_ctrl_asserts.sv
`timescale 1ns/100ps
module pwr_mode_ctrl_asserts
    import pwr_mode_pkg::*;
#(
    parameter int N_IRQ = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [N_IRQ-1:0] irq_flag,
    input wire logic [N_IRQ-1:0] irq_enable,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic count_input0,
    input wire logic count_input1,
    input wire logic cpu_clk_en,
    input wire logic osc_en,
    input wire logic count01_clk_en,
    input wire logic program_fetch_strobe,
    input wire logic ale_out,
    input wire logic [1:0] mode_state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_idle_entry: assert property (
        reg_wr && reg_addr == 8'h87 && reg_wdata[0] && mode_state == MODE_RUN
        && irq_flag == '0 |=> mode_state == MODE_IDLE) else $error("idle not entered");
    chk_stop_entry: assert property (
        reg_wr && reg_addr == 8'h87 && reg_wdata == 8'h02 && mode_state == MODE_RUN
        && irq_enable == '0 && irq_flag == '0 && ext_irq0_pin && ext_irq1_pin
        && !count_input0 && !count_input1 ##1 1 |-> mode_state == MODE_STOP)
        else $error("stop not entered");
    chk_idle_gating: assert property (
        mode_state == MODE_IDLE |-> !cpu_clk_en && osc_en) else $error("idle clocks");
    chk_stop_gating: assert property (
        mode_state == MODE_STOP |-> !osc_en && !cpu_clk_en && count01_clk_en)
        else $error("stop clocks");
    chk_idle_strobes: assert property (
        mode_state == MODE_IDLE |-> program_fetch_strobe && ale_out)
        else $error("idle strobes");
    chk_stop_strobes: assert property (
        mode_state == MODE_STOP |-> !program_fetch_strobe && !ale_out)
        else $error("stop strobes");
    chk_enabled_wake: assert property (
        mode_state != MODE_RUN && (irq_flag & irq_enable) != '0 |=> mode_state == MODE_RUN)
        else $error("no wake");
    chk_stop_refuse: assert property (
        reg_wr && reg_addr == 8'h87 && reg_wdata[1] && irq_enable[0] && !ext_irq0_pin
        && mode_state == MODE_RUN |=> mode_state != MODE_STOP) else $error("stop taken");
endmodule : pwr_mode_ctrl_asserts
bind pwr_mode_ctrl pwr_mode_ctrl_asserts #(.N_IRQ(N_IRQ)) chk_u (.clk_sys, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .irq_flag, .irq_enable, .ext_irq0_pin, .ext_irq1_pin,
    .count_input0, .count_input1, .cpu_clk_en,
    .osc_en, .count01_clk_en, .program_fetch_strobe, .ale_out, .mode_state);

//--- verif/wake_pin_model.sv
`timescale 1ns/100ps
module wake_pin_model (
    input wire logic clk_sys,
    input wire logic [3:0] want,
    input wire logic slow,
    output logic ext_irq0_pin,
    output logic ext_irq1_pin,
    output logic count_input0,
    output logic count_input1
);
    logic [3:0] dly;
    // slow source lags one extra cycle
    always_ff @(posedge clk_sys) begin
        dly <= want;
        {count_input1, count_input0, ext_irq1_pin, ext_irq0_pin} <= slow ? dly : want;
    end
endmodule : wake_pin_model

//--- verif/tb_idle_and_soft_power_down_control.sv
`timescale 1ns/100ps
module tb_idle_and_soft_power_down_control;
    import pwr_mode_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd, slow, ext_program_mode, run_fetch_strobe, run_ale;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, count_value0, count_value1, addr_high;
    logic [5:0] irq_flag, irq_enable;
    logic [3:0] want;
    logic [1:0] count_ext_mode, mode_state;
    logic [31:0] port_latch, port_out, port_oe;
    logic cpu_clk_en, osc_en, periph_clk_en, count01_clk_en, resume_next;
    logic program_fetch_strobe, ale_out, ext_irq0_pin, ext_irq1_pin, count_input0, count_input1;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    pwr_mode_ctrl #(.N_IRQ(6)) dut_u (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq_flag, .irq_enable, .ext_irq0_pin, .ext_irq1_pin, .count_input0,
        .count_input1, .count_ext_mode, .count_value0, .count_value1, .ext_program_mode,
        .addr_high, .port_latch, .run_fetch_strobe, .run_ale, .cpu_clk_en, .osc_en,
        .periph_clk_en, .count01_clk_en, .resume_next, .port_out, .port_oe,
        .program_fetch_strobe, .ale_out, .mode_state);
    wake_pin_model src_u (.clk_sys, .want, .slow, .ext_irq0_pin, .ext_irq1_pin,
        .count_input0, .count_input1);
    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    task conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            conclude;
        end
    end
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk_sys);
        reg_wr <= 0;
        #1;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1;
        cmp(reg_rdata, e);
    endtask : rd
    task flag(input logic [5:0] f, input logic [5:0] e);
        @(posedge clk_sys);
        irq_flag <= f;
        irq_enable <= e;
    endtask : flag
    task t_regs;
        rd(8'h87, 8'h00);
        cmp({program_fetch_strobe, ale_out, port_oe[29:0]}, {run_fetch_strobe, run_ale, 30'h3fffffff});
        wr(8'hf8, 8'h01);
        rd(8'hf8, 8'h01);
        wr(8'hf8, 8'h00);
        rd(8'h10, 8'h00);
    endtask : t_regs
    task t_idle;
        wr(8'h87, 8'h01);
        cmp(mode_state, MODE_IDLE);
        cmp({cpu_clk_en, osc_en, periph_clk_en}, 3'b011);
        cmp({program_fetch_strobe, ale_out}, 2'b11);
        cmp(port_out, port_latch);
        cmp(port_oe, '1);
        flag(6'h02, 6'h00);
        tick(2);
        cmp(mode_state, MODE_IDLE);
        flag(6'h02, 6'h02);
        tick(1);
        cmp({mode_state, resume_next}, {MODE_RUN, 1'b0});
        flag(6'h00, 6'h00);
        rd(8'h87, 8'h00);
    endtask : t_idle
    task t_idle_ext;
        ext_program_mode <= 1;
        wr(8'h87, 8'h21);
        cmp({port_out[23:16], port_oe[7:0]}, {addr_high, 8'h00});
        flag(6'h08, 6'h00);
        tick(1);
        cmp({mode_state, resume_next}, {MODE_RUN, 1'b1});
        flag(6'h00, 6'h00);
        ext_program_mode <= 0;
    endtask : t_idle_ext
    task t_stop;
        wr(8'h87, 8'h02);
        cmp(mode_state, MODE_STOP);
        cmp({cpu_clk_en, osc_en, periph_clk_en, count01_clk_en}, 4'b0001);
        cmp(port_oe, 32'hffffffff);
        cmp(port_out, port_latch);
        flag(6'h01, 6'h01);
        tick(1);
        cmp(mode_state, MODE_RUN);
        flag(6'h00, 6'h00);
        rd(8'h87, 8'h00);
    endtask : t_stop
    task t_float;
        wr(8'hf8, 8'h01);
        wr(8'h87, 8'h22);
        cmp(port_oe, 32'h0);
        cmp({program_fetch_strobe, ale_out}, 2'b00);
        flag(6'h20, 6'h00);
        tick(1);
        cmp(mode_state, MODE_RUN);
        flag(6'h00, 6'h00);
        wr(8'hf8, 8'h00);
    endtask : t_float
    task t_block;
        irq_enable <= 6'h01;
        want <= 4'b0010;
        slow <= 1;
        tick(4);
        wr(8'h87, 8'h02);
        cmp(mode_state, MODE_RUN);
        rd(8'h87, 8'h00);
        {irq_enable, want, count_ext_mode, count_value0, slow} <= {6'h02, 4'b0111, 2'b01, 8'hff, 1'b0};
        tick(3);
        wr(8'h87, 8'h02);
        cmp(mode_state, MODE_RUN);
        count_value0 <= 8'hfe;
        wr(8'h87, 8'h02);
        cmp(mode_state, MODE_STOP);
        flag(6'h02, 6'h02);
        tick(1);
        cmp(mode_state, MODE_RUN);
        {irq_flag, irq_enable, want, count_ext_mode} <= {12'h0, 4'b0011, 2'b00};
    endtask : t_block
    task t_reset;
        wr(8'h87, 8'h01);
        @(posedge clk_sys);
        rst <= 1;
        tick(1);
        rst <= 0;
        cmp(mode_state, MODE_RUN);
        rd(8'h87, 8'h00);
    endtask : t_reset
    initial begin
        {rst, reg_wr, reg_rd, slow, ext_program_mode, run_fetch_strobe, run_ale} = 7'b1000010;
        {reg_addr, reg_wdata, count_value0, count_value1, addr_high} = 40'h0;
        addr_high = 8'h5a;
        {irq_flag, irq_enable, count_ext_mode, want} = {14'h0, 4'b0011};
        port_latch = 32'hc3a55a3c;
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        t_regs;
        t_idle;
        t_idle_ext;
        t_stop;
        t_float;
        t_block;
        t_reset;
        conclude;
    end
endmodule : tb_idle_and_soft_power_down_control
